// ---- include/port_c_pkg.sv ----
// Contract
// [RQ1] Pin 5 output enabled drives output latch bit 5, analog select ignored.
// [RQ2] Pin 5 input shows pin level; digital input off while analog selected.
// [RQ3] Pin 5 output may carry the serial port 1 data output.
// [RQ4] Pin 6 output enabled drives output latch bit 6, analog select ignored.
// [RQ5] Pin 7 output enabled drives output latch bit 7, analog select ignored.
// [RQ6] Pin 6 output with analog off carries transceiver 1 transmit data.
// [RQ7] Pin 6 carries sync clock out when output, takes it in when input.
// [RQ8] Pin 7 input with analog off feeds transceiver 1 receive data.
// [RQ9] Pin 7 carries sync data out when output, takes it in when input.
// [RQ10] Pin 6 carries compare unit 3 output, or feeds its capture when input.
// [RQ11] Pin 6 output may carry PWM 3 output A.
// [RQ12] Pin 7 output may carry PWM 3 output B.
// [RQ13] Pin map bit set routes its remappable function to the default pin.
// [RQ14] Pin map bit clear routes its remappable function to the alternate pin.
// [RQ15] Unimplemented register bits, like analog select bits 1 and 0, read zero.
// [RQ16] Several enabled outputs on one pin: highest priority peripheral wins.
// [RQ17] Digital outputs still drive a pin in analog mode, same priority; pin 6 transmit is cut off here while pin 6 is analog.
// [RQ18] Pin level bit reads zero while its digital input is disabled.
package port_c_pkg;
    localparam logic [7:0] OFS_OUTPUT_LATCH = 8'h00;
    localparam logic [7:0] OFS_PIN_LEVEL = 8'h04;
    localparam logic [7:0] OFS_DIRECTION = 8'h08;
    localparam logic [7:0] OFS_ANALOG_SELECT = 8'h0c;
    localparam logic [7:0] OFS_SLEW = 8'h10;
    localparam logic [7:0] OFS_PIN_MAP = 8'h14;
    localparam logic [7:0] RST_OUTPUT_LATCH = 8'h00;
    localparam logic [7:0] RST_DIRECTION = 8'hff;
    localparam logic [7:0] RST_ANALOG_SELECT = 8'hfc;
    localparam logic [7:0] RST_SLEW = 8'h07;
    localparam logic [7:0] RST_PIN_MAP = 8'h0f;
    localparam logic [7:0] MASK_ANALOG_SELECT = 8'hfc;
    localparam logic [7:0] MASK_SLEW = 8'h07;
    localparam logic [7:0] MASK_PIN_MAP = 8'h0f;
    localparam int MAP_CCU2_BIT = 0;
    localparam int MAP_CCU3_BIT = 1;
    localparam int MAP_TIMER3_CLOCK_BIT = 2;
    localparam int MAP_PWM2B_BIT = 3;
    localparam int FIRST_PIN = 5;
    localparam int PIN_COUNT = 3;
    localparam int SLOTS = 4;
endpackage

// ---- include/port_c_mux_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface port_c_mux_if;
    logic [2:0] latch_bit;
    // Slot 3 has the highest priority
    logic [3:0] pin5_en;
    logic [3:0] pin5_val;
    logic [3:0] pin6_en;
    logic [3:0] pin6_val;
    logic [3:0] pin7_en;
    logic [3:0] pin7_val;
    logic [2:0] pad_out;
    modport ctrl (
        output latch_bit, pin5_en, pin5_val, pin6_en, pin6_val, pin7_en, pin7_val,
        input pad_out
    );
    modport mux (
        input latch_bit, pin5_en, pin5_val, pin6_en, pin6_val, pin7_en, pin7_val,
        output pad_out
    );
endinterface
`default_nettype wire

// ---- core/port_pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module port_pin_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] level_out
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_state_s;

    sync_state_s sync_q;
    sync_state_s sync_d;

    // First stage feeds only the second
    always_comb
    begin
        sync_d = sync_q;
        sync_d.stage1 = async_in;
        sync_d.stage2 = sync_q.stage1;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            sync_q <= '0;
        else if (ce)
            sync_q <= sync_d;
    end

    assign level_out = sync_q.stage2;
endmodule
`default_nettype wire

// ---- core/port_c_out_mux.sv ----
`timescale 1ns/1ps
`default_nettype none
module port_c_out_mux (
    port_c_mux_if.mux bus
);
    // Higher slots overwrite lower ones, the latch is the floor
    function automatic logic pick(
        input logic [3:0] en,
        input logic [3:0] val,
        input logic latch
    );
        logic r;
        r = latch;
        for (int i = 0; i < port_c_pkg::SLOTS; i++)
        begin
            if (en[i])
                r = val[i];
        end
        return r;
    endfunction

    assign bus.pad_out[0] = pick(bus.pin5_en, bus.pin5_val, bus.latch_bit[0]); // [RQ16]
    assign bus.pad_out[1] = pick(bus.pin6_en, bus.pin6_val, bus.latch_bit[1]); // [RQ16]
    assign bus.pad_out[2] = pick(bus.pin7_en, bus.pin7_val, bus.latch_bit[2]); // [RQ16]
endmodule
`default_nettype wire

// ---- core/port_c_upper_pin_mux.sv ----
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module port_c_upper_pin_mux (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [2:0] PIN_IN,
    output logic [2:0] PIN_OUT,
    output logic [2:0] PIN_OE_N,
    input wire logic SERIAL_PORT1_DATA_OUT,
    input wire logic SERIAL_PORT1_DATA_OUT_EN,
    input wire logic TRANSCEIVER1_TRANSMIT,
    input wire logic TRANSCEIVER1_TRANSMIT_EN,
    input wire logic TRANSCEIVER1_SYNC_CLOCK_OUT,
    input wire logic TRANSCEIVER1_SYNC_CLOCK_OUT_EN,
    input wire logic TRANSCEIVER1_SYNC_DATA_OUT,
    input wire logic TRANSCEIVER1_SYNC_DATA_OUT_EN,
    input wire logic CAPTURE_COMPARE_3_OUT,
    input wire logic CAPTURE_COMPARE_3_OUT_EN,
    input wire logic PWM3_OUTPUT_A,
    input wire logic PWM3_OUTPUT_A_EN,
    input wire logic PWM3_OUTPUT_B,
    input wire logic PWM3_OUTPUT_B_EN,
    output logic TRANSCEIVER1_RECEIVE,
    output logic TRANSCEIVER1_SYNC_CLOCK_IN,
    output logic TRANSCEIVER1_SYNC_DATA_IN,
    output logic CAPTURE_COMPARE_3_IN,
    output logic PWM2B_ON_DEFAULT_PIN,
    output logic TIMER3_CLOCK_ON_DEFAULT_PIN,
    output logic CCU3_ON_DEFAULT_PIN,
    output logic CCU2_ON_DEFAULT_PIN,
    output logic [2:0] ANALOG_SELECT_UPPER,
    output logic [2:0] SLEW_RATE_LIMIT
);
    typedef enum {
        SEL_LATCH,
        SEL_LEVEL,
        SEL_DIRECTION,
        SEL_ANALOG,
        SEL_SLEW,
        SEL_MAP,
        SEL_NONE
    } reg_sel_e;

    typedef struct packed {
        logic [7:0] output_latch_c;
        logic [7:0] direction_c;
        logic [7:0] analog_select_c;
        logic [7:0] slew_rate_control;
        logic [7:0] pin_map;
        logic ready;
        logic err;
        logic [31:0] rdata;
        logic [2:0] pad_out;
        logic [2:0] pad_oe_n;
        logic receive;
        logic sync_clock_in;
        logic sync_data_in;
        logic capture_in;
    } top_state_s;

    top_state_s state_q;
    top_state_s state_d;

    logic [2:0] pin_level;
    logic [2:0] dir_upper;
    logic [2:0] ansel_upper;
    logic [2:0] digital_in;
    logic ccu3_here;
    logic access;
    reg_sel_e sel;

    port_c_mux_if mux_bus ();

    port_pin_sync #(
        .WIDTH(port_c_pkg::PIN_COUNT)
    ) u_sync (
        .clk(CLK),
        .reset(RESET),
        .ce(CE),
        .async_in(PIN_IN),
        .level_out(pin_level)
    );

    port_c_out_mux u_mux (
        .bus(mux_bus)
    );

    // Shared by the read path and the write path
    function automatic reg_sel_e decode(input logic [7:0] addr);
        reg_sel_e s;
        s = SEL_NONE;
        case (addr)
            port_c_pkg::OFS_OUTPUT_LATCH: s = SEL_LATCH;
            port_c_pkg::OFS_PIN_LEVEL: s = SEL_LEVEL;
            port_c_pkg::OFS_DIRECTION: s = SEL_DIRECTION;
            port_c_pkg::OFS_ANALOG_SELECT: s = SEL_ANALOG;
            port_c_pkg::OFS_SLEW: s = SEL_SLEW;
            port_c_pkg::OFS_PIN_MAP: s = SEL_MAP;
            default: s = SEL_NONE;
        endcase
        return s;
    endfunction

    assign dir_upper = state_q.direction_c[port_c_pkg::FIRST_PIN +: port_c_pkg::PIN_COUNT];
    assign ansel_upper = state_q.analog_select_c[port_c_pkg::FIRST_PIN +: port_c_pkg::PIN_COUNT];
    // Analog select turns the digital input buffer off
    assign digital_in = pin_level & ~ansel_upper; // [RQ2]
    // Compare unit 3 sits here only on its alternate assignment
    assign ccu3_here = ~state_q.pin_map[port_c_pkg::MAP_CCU3_BIT]; // [RQ14]
    assign access = PSEL & PENABLE;
    assign sel = decode(PADDR);

    // Peripheral requests per pin, slot 3 highest; analog select is a term only in the
    // pin 6 transmit enable, other digital outputs keep driving the pin in analog mode
    assign mux_bus.latch_bit = // [RQ1] [RQ4] [RQ5]
        state_q.output_latch_c[port_c_pkg::FIRST_PIN +: port_c_pkg::PIN_COUNT];
    assign mux_bus.pin5_en = {SERIAL_PORT1_DATA_OUT_EN, 3'h0}; // [RQ3] [RQ17]
    assign mux_bus.pin5_val = {SERIAL_PORT1_DATA_OUT, 3'h0}; // [RQ3]
    assign mux_bus.pin6_en = {
        PWM3_OUTPUT_A_EN & ccu3_here,
        CAPTURE_COMPARE_3_OUT_EN & ccu3_here,
        TRANSCEIVER1_TRANSMIT_EN & ~ansel_upper[1],
        TRANSCEIVER1_SYNC_CLOCK_OUT_EN
    }; // [RQ6] [RQ7] [RQ10] [RQ11] [RQ16] [RQ17]
    assign mux_bus.pin6_val = {
        PWM3_OUTPUT_A,
        CAPTURE_COMPARE_3_OUT,
        TRANSCEIVER1_TRANSMIT,
        TRANSCEIVER1_SYNC_CLOCK_OUT
    }; // [RQ6] [RQ7] [RQ10] [RQ11]
    assign mux_bus.pin7_en = {
        PWM3_OUTPUT_B_EN,
        TRANSCEIVER1_SYNC_DATA_OUT_EN,
        2'h0
    }; // [RQ9] [RQ12] [RQ16] [RQ17]
    assign mux_bus.pin7_val = {
        PWM3_OUTPUT_B,
        TRANSCEIVER1_SYNC_DATA_OUT,
        2'h0
    }; // [RQ9] [RQ12]

    always_comb
    begin
        state_d = state_q;

        // Pad drive is registered so every pin output comes from a flop;
        // costs one cycle of latency on every peripheral output
        state_d.pad_out = mux_bus.pad_out;
        state_d.pad_oe_n = dir_upper; // [RQ1] [RQ4] [RQ5]

        // Inputs toward peripherals follow the direction bit
        state_d.receive = dir_upper[2] ? digital_in[2] : 1'b1; // [RQ8]
        state_d.sync_clock_in = dir_upper[1] & digital_in[1]; // [RQ7]
        state_d.sync_data_in = dir_upper[2] & digital_in[2]; // [RQ9]
        state_d.capture_in = dir_upper[1] & ccu3_here & digital_in[1]; // [RQ10]

        // Answer in the second access cycle; read data is registered at the same edge
        // as PREADY, so it is already stable while PREADY is high
        state_d.ready = access & ~state_q.ready;
        if (access & ~state_q.ready)
        begin
            state_d.err = (sel == SEL_NONE);
            state_d.rdata = '0;
            unique case (sel)
                SEL_LATCH: state_d.rdata[7:0] = state_q.output_latch_c;
                SEL_LEVEL:
                begin
                    // Lower pins are outside this block and read zero
                    state_d.rdata[port_c_pkg::FIRST_PIN +: port_c_pkg::PIN_COUNT] =
                        digital_in; // [RQ2] [RQ18]
                end
                SEL_DIRECTION: state_d.rdata[7:0] = state_q.direction_c;
                SEL_ANALOG:
                begin
                    state_d.rdata[7:0] =
                        state_q.analog_select_c & port_c_pkg::MASK_ANALOG_SELECT; // [RQ15]
                end
                SEL_SLEW:
                begin
                    state_d.rdata[7:0] =
                        state_q.slew_rate_control & port_c_pkg::MASK_SLEW; // [RQ15]
                end
                SEL_MAP:
                begin
                    state_d.rdata[7:0] = state_q.pin_map & port_c_pkg::MASK_PIN_MAP; // [RQ15]
                end
                SEL_NONE: state_d.rdata = '0;
            endcase
        end

        // Writes land only at the edge where PREADY is sampled high
        if (access & state_q.ready & PWRITE & PSTRB[0] & ~state_q.err)
        begin
            unique case (sel)
                SEL_LATCH: state_d.output_latch_c = PWDATA[7:0];
                // Writing the pin level register writes the latch
                SEL_LEVEL: state_d.output_latch_c = PWDATA[7:0];
                SEL_DIRECTION: state_d.direction_c = PWDATA[7:0];
                SEL_ANALOG:
                begin
                    state_d.analog_select_c =
                        PWDATA[7:0] & port_c_pkg::MASK_ANALOG_SELECT; // [RQ15]
                end
                SEL_SLEW:
                begin
                    state_d.slew_rate_control = PWDATA[7:0] & port_c_pkg::MASK_SLEW;
                end
                SEL_MAP:
                begin
                    state_d.pin_map = PWDATA[7:0] & port_c_pkg::MASK_PIN_MAP; // [RQ13] [RQ14]
                end
                SEL_NONE:
                begin
                end
            endcase
        end
        // Error flag stands only beside PREADY, so PSLVERR can come straight
        // from its flop; the write guard above still sees it at the ready edge
        if (!(access & ~state_q.ready))
        begin
            state_d.err = 1'b0;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            state_q <= '0;
            state_q.output_latch_c <= port_c_pkg::RST_OUTPUT_LATCH;
            state_q.direction_c <= port_c_pkg::RST_DIRECTION;
            state_q.analog_select_c <= port_c_pkg::RST_ANALOG_SELECT;
            state_q.slew_rate_control <= port_c_pkg::RST_SLEW;
            state_q.pin_map <= port_c_pkg::RST_PIN_MAP;
            // Pins come up undriven and receive line idles high
            state_q.pad_oe_n <= '1;
            state_q.receive <= 1'b1;
        end
        else if (CE)
        begin
            state_q <= state_d;
        end
    end

    assign PRDATA = state_q.rdata;
    assign PREADY = state_q.ready;
    assign PSLVERR = state_q.err;
    assign PIN_OUT = state_q.pad_out;
    assign PIN_OE_N = state_q.pad_oe_n;
    assign TRANSCEIVER1_RECEIVE = state_q.receive;
    assign TRANSCEIVER1_SYNC_CLOCK_IN = state_q.sync_clock_in;
    assign TRANSCEIVER1_SYNC_DATA_IN = state_q.sync_data_in;
    assign CAPTURE_COMPARE_3_IN = state_q.capture_in;
    // Set means default pin, clear means alternate pin
    assign PWM2B_ON_DEFAULT_PIN = state_q.pin_map[port_c_pkg::MAP_PWM2B_BIT]; // [RQ13] [RQ14]
    assign TIMER3_CLOCK_ON_DEFAULT_PIN =
        state_q.pin_map[port_c_pkg::MAP_TIMER3_CLOCK_BIT]; // [RQ13] [RQ14]
    assign CCU3_ON_DEFAULT_PIN = state_q.pin_map[port_c_pkg::MAP_CCU3_BIT]; // [RQ13] [RQ14]
    assign CCU2_ON_DEFAULT_PIN = state_q.pin_map[port_c_pkg::MAP_CCU2_BIT]; // [RQ13] [RQ14]
    assign ANALOG_SELECT_UPPER = ansel_upper;
    assign SLEW_RATE_LIMIT = state_q.slew_rate_control[2:0];
endmodule
`default_nettype wire

// ---- verification/pad_board.sv ----
`timescale 1ns/1ps
`default_nettype none
module pad_board (
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe_n,
    input wire logic [2:0] ext_en,
    input wire logic [2:0] ext_val,
    output logic [2:0] level
);
    // Pads released by both sides fall to the board pull-up, never to the last value
    always_comb
    begin
        for (int i = 0; i < 3; i++)
            level[i] = !pin_oe_n[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
    end
endmodule
`default_nettype wire

// ---- verification/port_c_upper_pin_mux_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module port_c_checker (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic [2:0] PIN_IN,
    input wire logic [2:0] PIN_OUT,
    input wire logic [2:0] PIN_OE_N,
    input wire logic SERIAL_PORT1_DATA_OUT,
    input wire logic SERIAL_PORT1_DATA_OUT_EN,
    input wire logic TRANSCEIVER1_SYNC_DATA_OUT,
    input wire logic TRANSCEIVER1_SYNC_DATA_OUT_EN,
    input wire logic PWM3_OUTPUT_A,
    input wire logic PWM3_OUTPUT_A_EN,
    input wire logic PWM3_OUTPUT_B,
    input wire logic PWM3_OUTPUT_B_EN,
    input wire logic TRANSCEIVER1_RECEIVE,
    input wire logic TRANSCEIVER1_SYNC_CLOCK_IN,
    input wire logic CCU3_ON_DEFAULT_PIN,
    input wire logic [2:0] ANALOG_SELECT_UPPER
);
    logic [2:0] age_q;
    logic [2:0] age_d;
    logic ok;
    always_comb
    begin
        age_d = (age_q == 3'h4) ? age_q : age_q + 3'h1;
    end
    always_ff @(posedge CLK)
    begin
        age_q <= RESET ? 3'h0 : age_d;
    end
    // Past values reach back three edges, so wait until they postdate reset
    assign ok = (age_q == 3'h4);
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    sequence setup_s;
        PSEL && !PENABLE;
    endsequence
    sequence access_s;
        PSEL && PENABLE;
    endsequence
    chk_ready_after_access: assert property (setup_s ##1 access_s |=> PREADY)
        else $error("Ready missing after access");
    chk_ready_one_cycle: assert property (PREADY |=> !PREADY)
        else $error("Ready held too long");
    chk_ansel_low_zero: assert property (PREADY && !PWRITE && PADDR == 8'h0c
        |-> PRDATA[1:0] == 2'h0 && PRDATA[31:8] == 24'h0) else $error("Analog low bits not 0");
    chk_sdo_pin5: assert property (ok && !PIN_OE_N[0]
        && $past(SERIAL_PORT1_DATA_OUT_EN) |-> PIN_OUT[0] == $past(SERIAL_PORT1_DATA_OUT))
        else $error("Pin 5 data out wrong");
    chk_pwm3a_pin6: assert property (ok && !PIN_OE_N[1]
        && $past(PWM3_OUTPUT_A_EN) && !$past(CCU3_ON_DEFAULT_PIN)
        |-> PIN_OUT[1] == $past(PWM3_OUTPUT_A))
        else $error("Pin 6 pwm wrong");
    chk_pwm3b_pin7: assert property (ok && !PIN_OE_N[2]
        && $past(PWM3_OUTPUT_B_EN) |-> PIN_OUT[2] == $past(PWM3_OUTPUT_B))
        else $error("Pin 7 pwm wrong");
    chk_sync_data_out: assert property (ok && !PIN_OE_N[2]
        && !$past(PWM3_OUTPUT_B_EN) && $past(TRANSCEIVER1_SYNC_DATA_OUT_EN)
        |-> PIN_OUT[2] == $past(TRANSCEIVER1_SYNC_DATA_OUT))
        else $error("Pin 7 sync data wrong");
    chk_sync_clock_in: assert property (ok && PIN_OE_N[1] && $past(PIN_OE_N[1])
        && !ANALOG_SELECT_UPPER[1] && !$past(ANALOG_SELECT_UPPER[1])
        |-> TRANSCEIVER1_SYNC_CLOCK_IN == $past(PIN_IN[1], 3)) else $error("Clock in wrong");
    chk_receive_pin7: assert property (ok && PIN_OE_N[2] && $past(PIN_OE_N[2])
        && !ANALOG_SELECT_UPPER[2] && !$past(ANALOG_SELECT_UPPER[2])
        |-> TRANSCEIVER1_RECEIVE == $past(PIN_IN[2], 3)) else $error("Receive wrong");
    chk_receive_analog: assert property (ok && PIN_OE_N[2] && $past(PIN_OE_N[2])
        && ANALOG_SELECT_UPPER[2] && $past(ANALOG_SELECT_UPPER[2]) |-> !TRANSCEIVER1_RECEIVE)
        else $error("Receive not gated");
endmodule
bind port_c_upper_pin_mux port_c_checker CHK (.*);
`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_top;
    logic CLK = 1'b0;
    logic RESET = 1'b1;
    logic CE = 1'b1;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [3:0] PSTRB = 4'hf;
    logic [31:0] PRDATA;
    logic PREADY, PSLVERR, TRANSCEIVER1_RECEIVE, TRANSCEIVER1_SYNC_CLOCK_IN;
    logic TRANSCEIVER1_SYNC_DATA_IN, CAPTURE_COMPARE_3_IN, PWM2B_ON_DEFAULT_PIN;
    logic TIMER3_CLOCK_ON_DEFAULT_PIN, CCU3_ON_DEFAULT_PIN, CCU2_ON_DEFAULT_PIN;
    logic [2:0] PIN_IN, PIN_OUT, PIN_OE_N, ANALOG_SELECT_UPPER, SLEW_RATE_LIMIT;
    logic [6:0] pen = 7'h00;
    logic [6:0] pval = 7'h00;
    logic [2:0] ext_en = 3'h0;
    logic [2:0] ext_val = 3'h0;
    logic [31:0] rd;
    logic slv;
    logic [3:0] map_pins;
    assign map_pins = {PWM2B_ON_DEFAULT_PIN, TIMER3_CLOCK_ON_DEFAULT_PIN,
        CCU3_ON_DEFAULT_PIN, CCU2_ON_DEFAULT_PIN};
    int err_count = 0;
    int n_compared = 0;
    always #5 CLK = ~CLK;
    port_c_upper_pin_mux DUT (.*,
        .SERIAL_PORT1_DATA_OUT(pval[0]), .SERIAL_PORT1_DATA_OUT_EN(pen[0]),
        .TRANSCEIVER1_TRANSMIT(pval[1]), .TRANSCEIVER1_TRANSMIT_EN(pen[1]),
        .TRANSCEIVER1_SYNC_CLOCK_OUT(pval[2]), .TRANSCEIVER1_SYNC_CLOCK_OUT_EN(pen[2]),
        .TRANSCEIVER1_SYNC_DATA_OUT(pval[3]), .TRANSCEIVER1_SYNC_DATA_OUT_EN(pen[3]),
        .CAPTURE_COMPARE_3_OUT(pval[4]), .CAPTURE_COMPARE_3_OUT_EN(pen[4]),
        .PWM3_OUTPUT_A(pval[5]), .PWM3_OUTPUT_A_EN(pen[5]),
        .PWM3_OUTPUT_B(pval[6]), .PWM3_OUTPUT_B_EN(pen[6]));
    pad_board PAD (.pin_out(PIN_OUT), .pin_oe_n(PIN_OE_N), .ext_en(ext_en),
        .ext_val(ext_val), .level(PIN_IN));
    task automatic give_verdict;
        $display("compared %0d errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        n = 0;
        do
        begin
            @(posedge CLK);
            n++;
        end
        while (PREADY !== 1'b1 && n < 20);
        rd = PRDATA;
        slv = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (PREADY !== 1'b1)
        begin
            err_count++;
            give_verdict;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0);
        `CHK("read data", {24'h0, e}, rd)
    endtask
    task automatic pins(input logic [6:0] e, input logic [6:0] v, input logic [2:0] x);
        @(posedge CLK);
        pen <= e;
        pval <= v;
        repeat (2) @(posedge CLK);
        `CHK("pad out", x, PIN_OUT)
    endtask
    task automatic ext(input logic [2:0] v);
        @(posedge CLK);
        ext_en <= 3'h7;
        ext_val <= v;
        repeat (4) @(posedge CLK);
    endtask
    task automatic t_reset;
        rchk(port_c_pkg::OFS_OUTPUT_LATCH, port_c_pkg::RST_OUTPUT_LATCH);
        rchk(port_c_pkg::OFS_DIRECTION, port_c_pkg::RST_DIRECTION);
        rchk(port_c_pkg::OFS_PIN_MAP, port_c_pkg::RST_PIN_MAP);
        `CHK("map pins", 4'hf, map_pins)
        apb(1'b0, 8'h18, 32'h0);
        `CHK("unmapped error", 1'b1, slv)
        wr(port_c_pkg::OFS_ANALOG_SELECT, 8'hff);
        rchk(port_c_pkg::OFS_ANALOG_SELECT, 8'hfc);
        wr(port_c_pkg::OFS_SLEW, 8'hff);
        rchk(port_c_pkg::OFS_SLEW, 8'h07);
        `CHK("slew pins", 3'h7, SLEW_RATE_LIMIT)
    endtask
    task automatic t_latch;
        wr(port_c_pkg::OFS_DIRECTION, 8'h00);
        wr(port_c_pkg::OFS_OUTPUT_LATCH, 8'ha0);
        repeat (3) @(posedge CLK);
        `CHK("pad enable", 3'b000, PIN_OE_N)
        `CHK("pad out", 3'b101, PIN_OUT)
        wr(port_c_pkg::OFS_PIN_LEVEL, 8'h40);
        repeat (3) @(posedge CLK);
        `CHK("pad out", 3'b010, PIN_OUT)
        rchk(port_c_pkg::OFS_OUTPUT_LATCH, 8'h40);
    endtask
    task automatic t_periph;
        pins(7'h01, 7'h01, 3'b011);
        pins(7'h02, 7'h00, 3'b010);
        pins(7'h06, 7'h00, 3'b000);
        pins(7'h20, 7'h00, 3'b010);
        wr(port_c_pkg::OFS_PIN_MAP, 8'h0d);
        pins(7'h30, 7'h10, 3'b000);
        pins(7'h10, 7'h00, 3'b000);
        `CHK("map pins", 4'hd, map_pins)
        wr(port_c_pkg::OFS_ANALOG_SELECT, 8'h00);
        pins(7'h06, 7'h02, 3'b010);
        pins(7'h48, 7'h08, 3'b010);
        pins(7'h08, 7'h08, 3'b110);
        pins(7'h00, 7'h00, 3'b010);
    endtask
    task automatic t_inputs;
        wr(port_c_pkg::OFS_DIRECTION, 8'hff);
        ext(3'b101);
        `CHK("receive", 1'b1, TRANSCEIVER1_RECEIVE)
        `CHK("sync data in", 1'b1, TRANSCEIVER1_SYNC_DATA_IN)
        `CHK("sync clock in", 1'b0, TRANSCEIVER1_SYNC_CLOCK_IN)
        `CHK("capture in", 1'b0, CAPTURE_COMPARE_3_IN)
        rchk(port_c_pkg::OFS_PIN_LEVEL, 8'ha0);
        ext(3'b010);
        `CHK("receive", 1'b0, TRANSCEIVER1_RECEIVE)
        `CHK("sync clock in", 1'b1, TRANSCEIVER1_SYNC_CLOCK_IN)
        `CHK("capture in", 1'b1, CAPTURE_COMPARE_3_IN)
        wr(port_c_pkg::OFS_ANALOG_SELECT, 8'he0);
        ext(3'b111);
        rchk(port_c_pkg::OFS_PIN_LEVEL, 8'h00);
        `CHK("receive", 1'b0, TRANSCEIVER1_RECEIVE)
        `CHK("sync clock in", 1'b0, TRANSCEIVER1_SYNC_CLOCK_IN)
        `CHK("analog pins", 3'b111, ANALOG_SELECT_UPPER)
    endtask
    initial
    begin
        repeat (4) @(posedge CLK);
        RESET <= 1'b0;
        t_reset;
        t_latch;
        t_periph;
        t_inputs;
        give_verdict;
    end
endmodule
`default_nettype wire
